// ---- pattern_skid_buffer.sv ----
// Purpose : Two-entry buffer between the pattern source and the lane output.
// Assumes : One clock, synchronous active-low reset, clock enable.
// Notes   : Data out comes straight from a register; ready is combinational.
`timescale 1ns/10ps

module pattern_skid_buffer #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_ce,
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic      [WIDTH-1:0] o_data
);

    // ****************************************************************
    // Occupancy and handshake
    // ****************************************************************
    logic [1:0]       count_q;
    logic [1:0]       count_d;
    logic [WIDTH-1:0] spare_q;
    logic             push;
    logic             pop;

    // A full buffer refuses the source, so a stalled sink loses no word.
    assign o_ready = (count_q != 2'h2);
    assign o_valid = (count_q != 2'h0);
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    assign count_d = count_q + {1'b0, push} - {1'b0, pop};

    // ****************************************************************
    // Storage
    // ****************************************************************
    // The head feeds the output; the spare holds a word caught in a stall.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            count_q <= 2'h0;
            o_data  <= '0;
            spare_q <= '0;
        end else if (i_ce) begin
            count_q <= count_d;
            if (pop) begin
                o_data <= (count_q == 2'h2) ? spare_q : i_data;
            end else if (push && count_q == 2'h0) begin
                o_data <= i_data;
            end
            if (push && !pop && count_q == 2'h1) begin
                spare_q <= i_data;
            end
        end
    end

endmodule : pattern_skid_buffer

// ---- jesd_test_pattern_generator.sv ----
// Purpose : Output test pattern source for a dual-link serial transmitter.
// Assumes : Link layer below supplies run, sync request and alignment end.
// Notes   : One beat carries one sample (or octet) for both links at once.
//
// Behaviour
// - Long pattern used when sample width 16.
// - Length is K times ceil((MS+2)/K).
// - Both links carry identical long pattern.
// - Frame zero samples equal converter index plus one.
// - Converter numbering restarts per link; I=0, Q=1.
// - Frame one samples equal sample position plus one.
// - Later frames carry mid-scale, two to N-1.
// - One control bit walks per frame below MS.
// - Control bits zero from frame MS onward.
// - Pattern starts after alignment, repeats while running.
// - D21.5 mode streams D21.5, either encoding.
// - K28.5 mode streams K28.5, 8b/10b only.
// - Repeated alignment mode never enters data phase.
// - Sync request forces code sync, then alignment, in long and repeated alignment modes.
// - RPAT mode repeats twelve fixed octets in order, 8b/10b only.
`timescale 1ns/10ps

package pattern_pkg;

    // ****************************************************************
    // Modes, states and constants
    // ****************************************************************
    typedef enum logic [2:0] {
        MODE_OFF     = 3'b000,
        MODE_LONG    = 3'b001,
        MODE_D215    = 3'b010,
        MODE_K285    = 3'b011,
        MODE_REP_ILA = 3'b100,
        MODE_RPAT    = 3'b101
    } mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CGS  = 2'b01,
        ST_ILAS = 2'b10,
        ST_DATA = 2'b11
    } link_state_t;

    localparam logic [4:0]  NPRIME_LONG = 5'h10;
    localparam logic [4:0]  WORD_BITS   = 5'h10;
    localparam logic [4:0]  CTRL_POS    = 5'h0f;
    localparam int          PAYLOAD_W   = 34;
    localparam logic [7:0]  CHAR_D215   = 8'hb5;
    localparam logic [7:0]  CHAR_K285   = 8'hbc;
    localparam logic [3:0]  RPAT_LAST   = 4'hb;
    // Octet k of the RPAT sequence sits at bits [8k +: 8].
    localparam logic [95:0] RPAT_SEQ    = {
        8'h59, 8'h35, 8'hfb, 8'h5e, 8'h14, 8'hb3,
        8'h8f, 8'h6b, 8'h47, 8'h23, 8'hd7, 8'hbe};

endpackage : pattern_pkg

module jesd_test_pattern_generator
    import pattern_pkg::*;
(
    input  wire logic        I_MCLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_CE,
    input  wire logic [2:0]  I_MODE,
    input  wire logic        I_ENC_64B66B,
    input  wire logic [4:0]  I_NPRIME,
    input  wire logic [4:0]  I_N_BITS,
    input  wire logic        I_CTRL_EN,
    input  wire logic [3:0]  I_CONV_COUNT,
    input  wire logic [3:0]  I_SAMPLES,
    input  wire logic [8:0]  I_FRAMES_MF,
    input  wire logic        I_LINK_RUN,
    input  wire logic        I_SYNC_REQ,
    input  wire logic        I_ILAS_DONE,
    output logic             O_CGS_ACTIVE,
    output logic             O_ILAS_ACTIVE,
    output logic             O_DATA_PHASE,
    output logic             O_VALID,
    input  wire logic        I_READY,
    output logic [15:0]      O_FIRST_LINK_LANE,
    output logic [15:0]      O_SECOND_LINK_LANE,
    output logic             O_CHAR_K,
    output logic             O_FRAME_END
);

    // ****************************************************************
    // Configuration capture
    // ****************************************************************
    mode_t       mode_q;
    logic        enc64_q;
    logic        nprime16_q;
    logic [4:0]  n_q;
    logic        ctrl_en_q;
    logic [3:0]  m_q;
    logic [3:0]  s_q;
    logic [8:0]  k_q;

    // Settings are taken only while the link is down, so a running
    // pattern never sees its geometry change under it.
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            mode_q     <= MODE_OFF;
            enc64_q    <= 1'b0;
            nprime16_q <= 1'b0;
            n_q        <= 5'h0f;
            ctrl_en_q  <= 1'b0;
            m_q        <= 4'h1;
            s_q        <= 4'h1;
            k_q        <= 9'h001;
        end else if (I_CE && !I_LINK_RUN) begin
            mode_q     <= mode_t'(I_MODE);
            enc64_q    <= I_ENC_64B66B;
            nprime16_q <= (I_NPRIME == NPRIME_LONG);
            n_q        <= I_N_BITS;
            ctrl_en_q  <= I_CTRL_EN;
            m_q        <= I_CONV_COUNT;
            s_q        <= I_SAMPLES;
            k_q        <= I_FRAMES_MF;
        end
    end

    // ****************************************************************
    // Link sequencing
    // ****************************************************************
    link_state_t state_q;
    link_state_t state_d;
    logic        uses_link;

    assign uses_link = (mode_q == MODE_LONG) || (mode_q == MODE_REP_ILA);

    // A sync request forces code group sync once the link has left idle; repeated alignment
    // loops in the alignment state and never reaches the data phase.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (uses_link) state_d = ST_CGS;
            ST_CGS:  if (!I_SYNC_REQ) state_d = ST_ILAS;
            ST_ILAS: begin
                if (I_SYNC_REQ) begin
                    state_d = ST_CGS;
                end else if (I_ILAS_DONE && mode_q == MODE_LONG) begin
                    state_d = ST_DATA;
                end
            end
            ST_DATA: if (I_SYNC_REQ) state_d = ST_CGS;
        endcase
        if (!I_LINK_RUN) state_d = ST_IDLE;
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            state_q <= ST_IDLE;
        end else if (I_CE) begin
            state_q <= state_d;
        end
    end

    assign O_CGS_ACTIVE  = (state_q == ST_CGS);
    assign O_ILAS_ACTIVE = (state_q == ST_ILAS);
    assign O_DATA_PHASE  = (state_q == ST_DATA);

    // ****************************************************************
    // Pattern position
    // ****************************************************************
    logic [3:0]  samp_q;
    logic [3:0]  conv_q;
    logic [7:0]  beat_q;
    logic [8:0]  frame_q;
    logic [8:0]  mf_q;
    logic [3:0]  rpat_q;
    logic        buf_ready;
    logic        gen_valid;
    logic        fire;
    logic        samp_last;
    logic        frame_end;
    logic        mf_last;
    logic        pat_end;
    logic [8:0]  ms_frames;
    logic        long_on;

    assign long_on   = (state_q == ST_DATA) && nprime16_q;
    assign ms_frames = {5'h00, m_q} * {5'h00, s_q};
    assign samp_last = (samp_q == s_q - 4'h1);
    assign frame_end = samp_last && (conv_q == m_q - 4'h1);
    assign mf_last   = (mf_q == k_q - 9'h001);
    // Ends on the multiframe edge after at least MS+2 frames.
    assign pat_end   = frame_end && mf_last
                       && (frame_q + 9'h001 >= ms_frames + 9'h002);
    assign fire      = gen_valid && buf_ready && I_CE;

    // Counters hold zero outside the data phase, so the first frame after
    // alignment, and after any restart, is frame zero.
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N || (I_CE && state_q != ST_DATA)) begin
            samp_q  <= 4'h0;
            conv_q  <= 4'h0;
            beat_q  <= 8'h00;
            frame_q <= 9'h000;
            mf_q    <= 9'h000;
        end else if (fire) begin
            samp_q <= samp_last ? 4'h0 : samp_q + 4'h1;
            beat_q <= frame_end ? 8'h00 : beat_q + 8'h01;
            if (frame_end) begin
                conv_q  <= 4'h0;
                frame_q <= pat_end ? 9'h000 : frame_q + 9'h001;
                mf_q    <= mf_last ? 9'h000 : mf_q + 9'h001;
            end else if (samp_last) begin
                conv_q <= conv_q + 4'h1;
            end
        end
    end

    // The RPAT index walks 0..11 and wraps.
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N || (I_CE && mode_q != MODE_RPAT)) begin
            rpat_q <= 4'h0;
        end else if (fire) begin
            rpat_q <= (rpat_q == RPAT_LAST) ? 4'h0 : rpat_q + 4'h1;
        end
    end

    // ****************************************************************
    // Beat contents
    // ****************************************************************
    // Converter index counts I then Q inside a link and starts at zero
    // again for the second link, so both links build the same words.
    function automatic logic [15:0] sample_word(
        input logic [8:0] frame,
        input logic [3:0] conv,
        input logic [3:0] samp,
        input logic [7:0] beat,
        input logic [4:0] n,
        input logic       ctrl_en,
        input logic [8:0] ms
    );
        logic [15:0] value;
        logic [15:0] word;
        value = 16'h0001 << (n - 5'h01);
        if (frame == 9'h000) value = {12'h000, conv} + 16'h0001;
        if (frame == 9'h001) value = {12'h000, samp} + 16'h0001;
        word = value << (WORD_BITS - n);
        if (ctrl_en && frame < ms && {1'b0, beat} == frame) begin
            word = word | (16'h0001 << (CTRL_POS - n));
        end
        return word;
    endfunction : sample_word

    logic [15:0] word_a;
    logic [15:0] word_b;
    logic [7:0]  octet;
    logic        octet_k;
    logic        octet_valid;
    logic [15:0] beat_a;
    logic [15:0] beat_b;
    logic        beat_end;

    // Both links compute from the same converter numbering, conv_q.
    assign word_a = sample_word(frame_q, conv_q, samp_q, beat_q, n_q,
                                ctrl_en_q, ms_frames);
    assign word_b = sample_word(frame_q, conv_q, samp_q, beat_q, n_q,
                                ctrl_en_q, ms_frames);

    // Octet modes need a running link; K28.5 and RPAT have no 64b/66b
    // form, so they stay silent with that encoding.
    assign octet_valid = I_LINK_RUN && (
        (mode_q == MODE_D215) ||
        (mode_q == MODE_K285 && !enc64_q) ||
        (mode_q == MODE_RPAT && !enc64_q));
    assign octet = (mode_q == MODE_D215) ? CHAR_D215 :
                   (mode_q == MODE_K285) ? CHAR_K285 :
                   RPAT_SEQ[{rpat_q, 3'b000} +: 8];
    assign octet_k = (mode_q == MODE_K285);

    assign gen_valid = (mode_q == MODE_LONG) ? long_on : octet_valid;
    assign beat_a = (mode_q == MODE_LONG) ? word_a : {8'h00, octet};
    assign beat_b = (mode_q == MODE_LONG) ? word_b : {8'h00, octet};
    assign beat_end = (mode_q == MODE_LONG) ? frame_end :
                      (mode_q == MODE_RPAT && rpat_q == RPAT_LAST);

    // ****************************************************************
    // Output buffer
    // ****************************************************************
    // A receiver stall backs up into this buffer and then freezes the
    // pattern counters, so no beat is dropped or repeated.
    pattern_skid_buffer #(
        .WIDTH (PAYLOAD_W)
    ) u_buffer (
        .i_clk   (I_MCLK),
        .i_rst_n (I_RST_N),
        .i_ce    (I_CE),
        .i_valid (gen_valid),
        .o_ready (buf_ready),
        .i_data  ({beat_end, octet_k, beat_a, beat_b}),
        .o_valid (O_VALID),
        .i_ready (I_READY),
        .o_data  ({O_FRAME_END, O_CHAR_K, O_FIRST_LINK_LANE,
                   O_SECOND_LINK_LANE})
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_RST_N);

    logic [15:0] samp_field;
    logic        ctrl_bit;
    logic        long_beat;

    assign samp_field = word_a >> (WORD_BITS - n_q);
    assign ctrl_bit   = |(word_a & (16'h0001 << (CTRL_POS - n_q)));
    assign long_beat  = gen_valid && mode_q == MODE_LONG;

    sequence s_ilas_end;
        state_q == ST_ILAS && I_CE && I_ILAS_DONE && !I_SYNC_REQ
        && I_LINK_RUN && mode_q == MODE_LONG;
    endsequence
    sequence s_data_start;
        state_q == ST_DATA && frame_q == 9'h000 && beat_q == 8'h00;
    endsequence

    chk_nprime_gate: assert property (
        long_beat |-> nprime16_q)
        else $error("long pattern with sample width other than 16");
    chk_pattern_wrap: assert property (
        fire && pat_end |=> frame_q == 9'h000 && mf_q == 9'h000)
        else $error("pattern did not wrap at its length");
    chk_links_equal: assert property (
        long_beat |-> word_a == word_b)
        else $error("links differ in long pattern");
    chk_frame0_value: assert property (
        long_beat && frame_q == 9'h000
        |-> samp_field == {12'h000, conv_q} + 16'h0001)
        else $error("frame zero sample not index plus one");
    chk_frame1_value: assert property (
        long_beat && frame_q == 9'h001
        |-> samp_field == {12'h000, samp_q} + 16'h0001)
        else $error("frame one sample not position plus one");
    chk_midscale_value: assert property (
        long_beat && frame_q > 9'h001
        |-> samp_field == (16'h0001 << (n_q - 5'h01)))
        else $error("later frame sample not mid-scale");
    chk_ctrl_walk: assert property (
        long_beat && ctrl_en_q && frame_q < ms_frames
        |-> ctrl_bit == ({1'b0, beat_q} == frame_q))
        else $error("walking control bit misplaced");
    chk_ctrl_clear: assert property (
        long_beat && frame_q >= ms_frames |-> !ctrl_bit)
        else $error("control bit set after walk ended");
    chk_start_after_ilas: assert property (
        s_ilas_end |=> s_data_start)
        else $error("pattern did not start after alignment");
    chk_d215_stream: assert property (
        gen_valid && mode_q == MODE_D215 |-> beat_a == 16'h00b5 && !octet_k)
        else $error("D21.5 stream wrong");
    chk_k285_encoding: assert property (
        mode_q == MODE_K285 && enc64_q |-> !gen_valid)
        else $error("K28.5 sent with 64b/66b");
    chk_rep_ila_loop: assert property (
        mode_q == MODE_REP_ILA |-> state_q != ST_DATA)
        else $error("repeated alignment entered data phase");
    chk_sync_to_cgs: assert property (
        I_CE && I_LINK_RUN && I_SYNC_REQ && state_q != ST_IDLE
        |=> state_q == ST_CGS)
        else $error("sync request did not force code sync");
    chk_rpat_order: assert property (
        fire && mode_q == MODE_RPAT && rpat_q == 4'h0
        |-> octet == 8'hbe ##1 (rpat_q == 4'h1 || !I_CE))
        else $error("RPAT sequence out of order");
    chk_frame_reset: assert property (
        I_CE && state_q == ST_DATA && !I_LINK_RUN
        |=> state_q == ST_IDLE ##1 (frame_q == 9'h000 || !$past(I_CE)))
        else $error("frame counter not cleared on restart");

endmodule : jesd_test_pattern_generator

// ---- lane_receiver_model.sv ----
// Purpose : Receiver-side model: accepts beats and raises sync requests.
// Assumes : One clock; the model changes its outputs on the falling edge.
// Notes   : Slow mode accepts one beat in three, so the buffer backs up.
`timescale 1ns/10ps

module lane_receiver_model (
    input  wire logic i_clk,
    input  wire logic i_slow,
    input  wire logic i_resync,
    output logic      o_ready,
    output logic      o_sync_req
);
    logic [1:0] phase_q = 2'h0;

    // ****************************************************************
    // Acceptance and sync request
    // ****************************************************************
    // Ready is held for a whole cycle, so the edge that samples it
    // never sees a change in flight.
    always @(negedge i_clk) begin
        phase_q    <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
        o_ready    <= !i_slow || (phase_q == 2'h0);
        o_sync_req <= i_resync;
    end
endmodule : lane_receiver_model

// ---- tb_top.sv ----
// Purpose : Self-checking bench for the test pattern generator.
// Assumes : Inputs change on the falling edge; outputs read just after.
// Notes   : Expected words are rebuilt here from the pattern rules.
`timescale 1ns/10ps

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end

module tb_top;
    import pattern_pkg::*;

    logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, enc = 1'b0;
    logic        ctrl = 1'b0, run = 1'b0, done = 1'b0;
    logic        slow = 1'b0, resync = 1'b0;
    logic [2:0]  mode = 3'h0;
    logic [4:0]  nprime = 5'h10, nbits = 5'h0f;
    logic [3:0]  mcnt = 4'h1, scnt = 4'h1;
    logic [8:0]  kcnt = 9'h1;
    logic        ready, sync, cgs, ilas, data, valid, char_k, fend;
    logic [15:0] lane_a, lane_b;
    int          fails = 0, checks = 0;

    jesd_test_pattern_generator dut (
        .I_MCLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_MODE(mode),
        .I_ENC_64B66B(enc), .I_NPRIME(nprime), .I_N_BITS(nbits),
        .I_CTRL_EN(ctrl), .I_CONV_COUNT(mcnt), .I_SAMPLES(scnt),
        .I_FRAMES_MF(kcnt), .I_LINK_RUN(run), .I_SYNC_REQ(sync),
        .I_ILAS_DONE(done), .O_CGS_ACTIVE(cgs), .O_ILAS_ACTIVE(ilas),
        .O_DATA_PHASE(data), .O_VALID(valid), .I_READY(ready),
        .O_FIRST_LINK_LANE(lane_a), .O_SECOND_LINK_LANE(lane_b),
        .O_CHAR_K(char_k), .O_FRAME_END(fend));

    lane_receiver_model rx (
        .i_clk(clk), .i_slow(slow), .i_resync(resync),
        .o_ready(ready), .o_sync_req(sync));

    // ****************************************************************
    // Clock and shared tasks
    // ****************************************************************
    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    task test_done;
        $display("Comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    // Bounded wait for one state flag: 0 sync, 1 alignment, 2 data.
    task wait_flag(input int which);
        int i;
        logic f;
        for (i = 0; i < 50; i++) begin
            @(negedge clk);
            f = (which == 0) ? cgs : (which == 1) ? ilas : data;
            if (f === 1'b1) break;
        end
        `CHK(f, 1'b1)
    endtask : wait_flag

    task pulse_done;
        wait_flag(1);
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
    endtask : pulse_done

    // Waits for the next accepted beat and compares it. The look comes
    // just after the falling edge, once the model has set the ready that
    // the next rising edge samples, so the beat seen is the one taken.
    task get_beat(input logic [15:0] w, input logic fe, input logic k);
        int i;
        for (i = 0; i < 60; i++) begin
            @(negedge clk);
            #1;
            if (valid === 1'b1 && ready === 1'b1) break;
        end
        `CHK(valid & ready, 1'b1)
        `CHK(lane_a, w)
        `CHK(lane_b, w)
        `CHK(fend, fe)
        `CHK(char_k, k)
    endtask : get_beat

    task link_down;
        @(negedge clk);
        run = 1'b0;
        @(negedge clk);
    endtask : link_down

    // Mode is only changed while the link is held down.
    task link_up(input logic [2:0] md, input logic e);
        mode = md;
        enc = e;
        repeat (2) @(negedge clk);
        run = 1'b1;
        if (md == MODE_LONG || md == MODE_REP_ILA) pulse_done;
    endtask : link_up

    // One full pattern plus the first frame of its repeat.
    task run_long(input int m, input int s, input int n, input logic ct,
                  input int k);
        int f, c, x, v, len, ff;
        logic [15:0] w;
        link_down;
        mcnt = 4'(m);
        scnt = 4'(s);
        nbits = 5'(n);
        ctrl = ct;
        kcnt = 9'(k);
        nprime = 5'h10;
        link_up(MODE_LONG, 1'b0);
        len = k * ((m * s + 2 + k - 1) / k);
        for (f = 0; f <= len; f++) begin
            ff = f % len;
            for (c = 0; c < m; c++) begin
                for (x = 0; x < s; x++) begin
                    v = (ff == 0) ? c + 1 : (ff == 1) ? x + 1 : 1 << (n - 1);
                    w = 16'(v << (16 - n));
                    if (ct && ff < m * s && ff == c * s + x) w[15-n] = 1'b1;
                    get_beat(w, c == m - 1 && x == s - 1, 1'b0);
                end
            end
        end
    endtask : run_long

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task test_long;
        slow = 1'b1;
        run_long(1, 2, 15, 1'b1, 3);
        slow = 1'b0;
        run_long(2, 2, 14, 1'b1, 4);
        run_long(2, 1, 12, 1'b0, 1);
    endtask : test_long

    // A sync request in the data phase must restart from frame zero.
    task test_restart;
        run_long(1, 2, 15, 1'b1, 3);
        resync = 1'b1;
        wait_flag(0);
        `CHK(data, 1'b0)
        repeat (4) @(negedge clk);
        resync = 1'b0;
        pulse_done;
        get_beat(16'h0003, 1'b0, 1'b0);
        get_beat(16'h0002, 1'b1, 1'b0);
    endtask : test_restart

    task test_rep_ila;
        link_down;
        link_up(MODE_REP_ILA, 1'b0);
        repeat (6) @(negedge clk);
        `CHK(ilas, 1'b1)
        `CHK(data | valid, 1'b0)
        resync = 1'b1;
        wait_flag(0);
        resync = 1'b0;
        wait_flag(1);
    endtask : test_rep_ila

    task test_octets;
        logic [7:0] rp [12] = '{8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f,
                                8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};
        int i;
        link_down;
        link_up(MODE_D215, 1'b0);
        for (i = 0; i < 4; i++) get_beat(16'h00b5, 1'b0, 1'b0);
        link_down;
        link_up(MODE_D215, 1'b1);
        for (i = 0; i < 4; i++) get_beat(16'h00b5, 1'b0, 1'b0);
        link_down;
        link_up(MODE_K285, 1'b0);
        for (i = 0; i < 4; i++) get_beat(16'h00bc, 1'b0, 1'b1);
        link_down;
        link_up(MODE_RPAT, 1'b0);
        for (i = 0; i < 24; i++)
            get_beat({8'h00, rp[i % 12]}, i % 12 == 11, 1'b0);
    endtask : test_octets

    // Modes that must stay silent: wrong encoding or sample width.
    task test_no_beats;
        logic [2:0] md [3] = '{MODE_K285, MODE_RPAT, MODE_LONG};
        logic [4:0] np [3] = '{5'h10, 5'h10, 5'h0c};
        logic seen;
        int i;
        for (i = 0; i < 3; i++) begin
            link_down;
            nprime = np[i];
            link_up(md[i], i < 2);
            seen = 1'b0;
            repeat (20) begin
                @(negedge clk);
                if (valid === 1'b1) seen = 1'b1;
            end
            `CHK(seen, 1'b0)
        end
        nprime = 5'h10;
    endtask : test_no_beats

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    // Reset is held for twelve cycles before any traffic.
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        test_long;
        test_restart;
        test_rep_ila;
        test_octets;
        test_no_beats;
        test_done;
    end

    // The whole run needs a few hundred cycles; this bound is ample.
    initial begin
        #400000;
        fails++;
        test_done;
    end
endmodule : tb_top
